// ===== tb/erxf_phy_model.sv
// Behavioural transceiver model that sends receive frames to the filter.
`timescale 1ns/100ps
module erxf_phy_model
(
   output logic rx_clk_pin,
   output logic rx_valid_pin,
   output logic [3:0] rx_data_pin
);
   initial
   begin
      rx_clk_pin = 1'b0;
      rx_valid_pin = 1'b0;
      rx_data_pin = 4'h0;
   end
   task automatic tick;
      #160 rx_clk_pin = 1'b1;
      #160 rx_clk_pin = 1'b0;
   endtask : tick
   // Sends bytes lsb or low nibble first; two clock ticks with valid low follow the frame, then the clock stops.
   task automatic send(input logic [7:0] q[$], input logic ser);
      int i;
      int k;
      for (i = 0; i < q.size(); i++)
         for (k = 0; k < 8; k += ser ? 1 : 4)
         begin
            rx_valid_pin = 1'b1;
            rx_data_pin = ser ? {{3{~q[i][k]}}, q[i][k]} : q[i][k +: 4];
            tick();
         end
      rx_valid_pin = 1'b0;
      repeat (2)
      begin
         rx_data_pin = ~rx_data_pin;
         tick();
      end
   endtask : send
endmodule : erxf_phy_model

// ===== tb/erxf_tb_top.sv
// Testbench for the receive frame filter with register and frame tests.
`timescale 1ns/100ps
module erxf_tb_top;
   import erxf_pkg::*;
   logic clk, rst, reg_wr, reg_rd, rx_clk_pin, rx_valid_pin;
   logic rx_byte_valid, frame_accept, frame_reject, status_valid, irq;
   logic [3:0] rx_data_pin;
   logic [7:0] reg_addr, rx_byte, first_b;
   logic [31:0] reg_wdata, reg_rdata, status_word, st_seen, d;
   int num_errors = 0, compares = 0, n_acc, n_rej, n_st, n_byte;
   logic [47:0] sta = 48'h0234_5678_9abc;
   logic [47:0] uni = 48'h0a00_0000_0001;
   logic [47:0] grp = 48'h0100_5e00_0001;
   logic [47:0] bc = 48'hffff_ffff_ffff;
   erxf_top dut(.clk(clk), .rst(rst), .rx_clk_pin(rx_clk_pin),
      .rx_valid_pin(rx_valid_pin), .rx_data_pin(rx_data_pin),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_byte(rx_byte),
      .rx_byte_valid(rx_byte_valid), .frame_accept(frame_accept),
      .frame_reject(frame_reject), .status_word(status_word),
      .status_valid(status_valid), .irq(irq));
   erxf_phy_model phy(.rx_clk_pin(rx_clk_pin), .rx_valid_pin(rx_valid_pin),
      .rx_data_pin(rx_data_pin));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (rx_byte_valid === 1'b1)
      begin
         if (n_byte == 0)
            first_b = rx_byte;
         n_byte++;
      end
      if (frame_accept === 1'b1)
         n_acc++;
      if (frame_reject === 1'b1)
         n_rej++;
      if (status_valid === 1'b1)
      begin
         n_st++;
         st_seen = status_word;
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp,
      input string msg);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h",
            $time, msg, seen, exp);
      end
   endtask : check
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd
   function automatic logic [31:0] crc8(input logic [31:0] c,
      input logic [7:0] b);
      for (int k = 0; k < 8; k++)
         c = {c[30:0], 1'b0} ^ ((c[31] ^ b[k]) ? CRC_POLY : 32'h0);
      return c;
   endfunction : crc8
   function automatic logic [5:0] hidx(input logic [47:0] a);
      logic [31:0] c;
      c = CRC_INIT;
      for (int i = 0; i < 6; i++)
         c = crc8(c, a[47 - 8 * i -: 8]);
      return c[31:26];
   endfunction : hidx
   task hset(input logic [7:0] up, input logic [47:0] a);
      logic [5:0] x;
      x = hidx(a);
      wr(up, x[5] ? 32'h1 << x[4:0] : 32'h0);
      wr(up + 8'h4, x[5] ? 32'h0 : 32'h1 << x[4:0]);
   endtask : hset
   task run(input string nm, input logic [4:0] ctl, input logic [47:0] da,
      input int len, input logic [15:0] typ, input logic ser,
      input logic bad, input logic acc, input logic rej,
      input logic [7:0] flg);
      logic [7:0] q[$];
      logic [7:0] f;
      logic [31:0] c;
      int i;
      q = {};
      c = CRC_INIT;
      for (i = 0; i < len - 4; i++)
      begin
         q.push_back(i < 6 ? da[47 - 8 * i -: 8] : i < 12 ? 8'h02 :
            i == 12 ? typ[15:8] : i == 13 ? typ[7:0] : 8'(i - 14));
         c = crc8(c, q[i]);
      end
      for (i = 0; i < 32; i += 8)
      begin
         f = {<<{c[31 - i -: 8]}};
         q.push_back(~f);
      end
      q.push_front(8'hd5);
      repeat (7) q.push_front(8'h55);
      if (bad)
         q[2] = 8'h57;
      wr(CTRL_OFS, {27'h0, ctl});
      wr(DESC_OFS, 32'h8000_0000);
      @(posedge clk);
      #1;
      {n_acc, n_rej, n_st, n_byte} = '0;
      first_b = 8'h0;
      phy.send(q, ser);
      repeat (60) @(posedge clk);
      check(n_byte, bad ? 0 : (rej && len >= 64 && typ != 16'h8808) ? 6
         : len, "byte count");
      check(first_b, bad ? 8'h0 : da[47:40], "first byte");
      check(n_acc, acc, "accept");
      check(n_rej, rej, "reject");
      check(n_st, acc, "status count");
      if (acc)
         check(st_seen[23:0], {flg, 16'(len)}, "status");
      rd(DESC_OFS, d);
      check({d[31:30], d[23:0]}, acc ? {2'b01, flg, 16'(len)} :
         26'h200_0000, "descriptor");
      check(irq, acc, "irq");
      rd(EVENT_OFS, d);
      check(d[1:0], acc ? {flg[4], 1'b1} : 2'b00, "events");
      wr(EVENT_OFS, 32'h3);
      repeat (2) @(posedge clk);
      #1;
      check(irq, 1'b0, "irq cleared");
      $display("Frame test %s done", nm);
   endtask : run
   task test_done;
      $display("Comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   initial
   begin
      #2_400_000;
      num_errors++;
      test_done();
   end
   initial
   begin
      {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 42'h0};
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(CTRL_OFS, d);
      check(d, 32'h0, "control reset");
      rd(LIMIT_OFS, d);
      check(d, 32'h5ee, "limit reset");
      rd(DESC_OFS, d);
      check(d, 32'h0, "descriptor reset");
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40, d);
      check(d, 32'h0, "unmapped read");
      @(posedge clk);
      #1;
      check(reg_rdata, 32'h0, "read data released");
      $display("Register test done");
      wr(STA_LOW_OFS, sta[47:16]);
      wr(STA_HIGH_OFS, {sta[15:0], 16'h0});
      wr(MASK_OFS, 32'h1);
      wr(UHASH_UP_OFS, 32'h0);
      wr(UHASH_LO_OFS, 32'h0);
      hset(GHASH_UP_OFS, grp);
      run("bcast", 5'h03, bc, 70, 16'h0800, 0, 0, 1, 0, 8'h40);
      run("station", 5'h03, sta, 64, 16'h0800, 0, 0, 1, 0, 8'h00);
      run("uni_miss", 5'h03, uni, 64, 16'h0800, 0, 0, 0, 1, 8'h00);
      run("accept_all", 5'h0b, uni, 64, 16'h0800, 0, 0, 1, 0, 8'h80);
      hset(UHASH_UP_OFS, uni);
      run("uni_hash", 5'h03, uni, 64, 16'h0800, 0, 0, 1, 0, 8'h00);
      run("bc_block", 5'h07, bc, 64, 16'h0800, 0, 0, 0, 1, 8'h00);
      run("bc_blk_all", 5'h0f, bc, 64, 16'h0800, 0, 0, 1, 0, 8'hc0);
      run("group", 5'h03, grp, 64, 16'h0800, 0, 0, 1, 0, 8'h20);
      run("runt", 5'h03, bc, 63, 16'h0800, 0, 0, 0, 1, 8'h00);
      run("pause", 5'h13, PAUSE_ADDR, 64, 16'h8808, 0, 0, 0, 1, 8'h00);
      wr(LIMIT_OFS, 32'd70);
      run("long", 5'h03, bc, 80, 16'h0800, 0, 0, 1, 0, 8'h50);
      wr(LIMIT_OFS, 32'd1518);
      run("serial", 5'h01, bc, 64, 16'h0800, 1, 0, 1, 0, 8'h40);
      run("serial_bad", 5'h01, bc, 64, 16'h0800, 1, 1, 0, 0, 8'h00);
      test_done();
   end
endmodule : erxf_tb_top

// ===== verilog/erxf_pkg.sv
// Package with register map, field positions, reset values and states.
package erxf_pkg;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] LIMIT_OFS = 8'h04;
   localparam logic [7:0] STA_LOW_OFS = 8'h08;
   localparam logic [7:0] STA_HIGH_OFS = 8'h0c;
   localparam logic [7:0] UHASH_UP_OFS = 8'h10;
   localparam logic [7:0] UHASH_LO_OFS = 8'h14;
   localparam logic [7:0] GHASH_UP_OFS = 8'h18;
   localparam logic [7:0] GHASH_LO_OFS = 8'h1c;
   localparam logic [7:0] EVENT_OFS = 8'h20;
   localparam logic [7:0] MASK_OFS = 8'h24;
   localparam logic [7:0] DESC_OFS = 8'h28;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_NIBBLE_BIT = 1;
   localparam int CTRL_BBLOCK_BIT = 2;
   localparam int CTRL_ALL_BIT = 3;
   localparam int CTRL_FCE_BIT = 4;
   localparam int EV_FRAME_BIT = 0;
   localparam int EV_OVER_BIT = 1;
   localparam int DESC_EMPTY_BIT = 31;
   localparam int DESC_LAST_BIT = 30;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   localparam logic [15:0] LIMIT_RESET = 16'h05ee;
   localparam logic [4:0] SER_IGNORE_BITS = 5'h10;
   localparam logic [4:0] SER_ALT_LAST = 5'h15;
   localparam logic [15:0] ACCEPT_BYTES = 16'h0040;
   localparam logic [15:0] DA_BYTES = 16'h0006;
   localparam logic [15:0] TYPE_FIRST = 16'h000c;
   localparam logic [15:0] OPCODE_LAST = 16'h0010;
   localparam logic [31:0] PAUSE_TYPE_OP = 32'h8808_0001;
   localparam logic [47:0] PAUSE_ADDR = 48'h0180_c200_0001;
   localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;
   localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
   localparam logic [31:0] CRC_RESIDUE = 32'hc704_dd7b;
   localparam logic [3:0] NIB_PRE = 4'h5;
   localparam logic [3:0] NIB_SFD = 4'hd;
   typedef enum logic [1:0] {
      ERXF_IDLE = 2'b00,
      ERXF_PRE = 2'b01,
      ERXF_DATA = 2'b10,
      ERXF_DROP = 2'b11
   } erxf_state_e;
endpackage : erxf_pkg

// ===== verilog/erxf_top.sv
// Receive framing and destination address filter of a 10/100 MAC.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module erxf_top
   import erxf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic rx_clk_pin,
   input wire logic rx_valid_pin,
   input wire logic [3:0] rx_data_pin,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic [7:0] rx_byte,
   output logic rx_byte_valid,
   output logic frame_accept,
   output logic frame_reject,
   output logic [31:0] status_word,
   output logic status_valid,
   output logic irq
);
   import erxf_pkg::*;

   function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                            input logic [7:0] b);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
      begin
         r = {r[30:0], 1'b0} ^ ((r[31] ^ b[i]) ? CRC_POLY : 32'h0000_0000);
      end
      return r;
   endfunction : crc_byte

   function automatic logic hash_hit(input logic [31:0] up,
                                     input logic [31:0] lo,
                                     input logic [5:0] idx);
      return idx[5] ? up[idx[4:0]] : lo[idx[4:0]];
   endfunction : hash_hit

   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;
   logic clk_s3_reg;
   logic [4:0] rx_control_reg;
   logic [15:0] frame_length_limit;
   logic [31:0] station_addr_low;
   logic [31:0] station_addr_high;
   logic [31:0] unicast_hash_upper;
   logic [31:0] unicast_hash_lower;
   logic [31:0] group_hash_upper;
   logic [31:0] group_hash_lower;
   logic [1:0] irq_event_reg;
   logic [1:0] irq_mask_reg;
   logic [31:0] rx_descriptor;
   erxf_state_e state_reg;
   erxf_state_e state_next;
   logic [4:0] bit_cnt_reg;
   logic prev_bit_reg;
   logic [3:0] prev_nib_reg;
   logic [7:0] shift_reg;
   logic [2:0] part_reg;
   logic [15:0] byte_cnt_reg;
   logic [31:0] crc_reg;
   logic [47:0] da_reg;
   logic [31:0] type_op_reg;
   logic decide_reg;
   logic decided_reg;
   logic accepted_reg;
   logic miss_reg;
   logic bc_reg;
   logic mc_reg;
   logic pause_cand_reg;
   logic pause_reg;
   logic over_reg;

   wire link_edge = sync2_reg[5] & ~clk_s3_reg;
   wire valid_s = sync2_reg[4];
   wire [3:0] data_s = sync2_reg[3:0];
   wire mac_enable = rx_control_reg[CTRL_EN_BIT];
   wire nibble_mode = rx_control_reg[CTRL_NIBBLE_BIT];
   wire broadcast_block = rx_control_reg[CTRL_BBLOCK_BIT];
   wire accept_all_mode = rx_control_reg[CTRL_ALL_BIT];
   wire flow_control_enable = rx_control_reg[CTRL_FCE_BIT];
   wire serial_rx_bit = data_s[0];
   wire sample = link_edge & valid_s;
   wire frame_end = link_edge & ~valid_s;
   wire ser_alt_err = (bit_cnt_reg > SER_IGNORE_BITS)
                      & (serial_rx_bit == prev_bit_reg);
   wire ser_sfd = (bit_cnt_reg > SER_ALT_LAST) & serial_rx_bit
                  & prev_bit_reg;
   wire ser_bad = (bit_cnt_reg > SER_ALT_LAST) & ~serial_rx_bit
                  & ~prev_bit_reg;
   wire nib_zero = (~prev_bit_reg & ~data_s[0]) | (~data_s[0] & ~data_s[1])
                   | (~data_s[1] & ~data_s[2]) | (~data_s[2] & ~data_s[3]);
   wire nib_sfd = (prev_nib_reg == NIB_PRE) & (data_s == NIB_SFD);
   wire byte_done = sample & (state_reg == ERXF_DATA)
                    & (nibble_mode ? part_reg[0] : (part_reg == 3'h7));
   wire [7:0] byte_in = nibble_mode ? {data_s, shift_reg[3:0]}
                                    : {serial_rx_bit, shift_reg[7:1]};
   wire [15:0] byte_cnt_inc = byte_cnt_reg + 16'h0001;
   wire [47:0] station_addr = {station_addr_low, station_addr_high[31:16]};
   wire [5:0] hash_idx = crc_reg[31:26];
   wire is_group = da_reg[40];
   wire is_bcast = &da_reg;
   wire group_hit = hash_hit(group_hash_upper, group_hash_lower, hash_idx);
   wire uni_hit = hash_hit(unicast_hash_upper, unicast_hash_lower, hash_idx);
   wire pause_da = da_reg == PAUSE_ADDR;
   wire station_hit = da_reg == station_addr;
   wire addr_hit = is_bcast ? ~broadcast_block
                 : is_group ? (flow_control_enable ? pause_da : group_hit)
                 : (station_hit | uni_hit);
   wire pause_cand = flow_control_enable & ~is_bcast
                     & (is_group ? pause_da : station_hit);
   wire accept_now = addr_hit | accept_all_mode;
   wire crc_err = crc_reg != CRC_RESIDUE;
   wire runt = byte_cnt_reg < ACCEPT_BYTES;
   wire pause_drop = pause_reg & ~crc_err;
   wire end_ok = frame_end & (state_reg == ERXF_DATA) & ~runt & ~pause_drop;
   wire end_flush = frame_end & (state_reg == ERXF_DATA) & (runt | pause_drop);
   wire reach_64 = byte_done & (byte_cnt_inc == ACCEPT_BYTES)
                   & decided_reg & ~pause_reg;
   wire nonaligned = nibble_mode ? part_reg[0] : (part_reg != 3'h0);
   wire [23:0] status_flags = {miss_reg, bc_reg, mc_reg, over_reg,
                               nonaligned, crc_err, 2'b00, byte_cnt_reg};
   wire wr_desc = reg_wr & (reg_addr == DESC_OFS);
   wire [1:0] ev_set = {byte_done & (byte_cnt_inc > frame_length_limit)
                        & ~over_reg, end_ok};
   wire [1:0] ev_clr = (reg_wr & (reg_addr == EVENT_OFS))
                       ? reg_wdata[1:0] : 2'b00;
   wire [31:0] rd_mux =
      (reg_addr == CTRL_OFS) ? {27'h0000000, rx_control_reg} :
      (reg_addr == LIMIT_OFS) ? {16'h0000, frame_length_limit} :
      (reg_addr == STA_LOW_OFS) ? station_addr_low :
      (reg_addr == STA_HIGH_OFS) ? station_addr_high :
      (reg_addr == UHASH_UP_OFS) ? unicast_hash_upper :
      (reg_addr == UHASH_LO_OFS) ? unicast_hash_lower :
      (reg_addr == GHASH_UP_OFS) ? group_hash_upper :
      (reg_addr == GHASH_LO_OFS) ? group_hash_lower :
      (reg_addr == EVENT_OFS) ? {30'h00000000, irq_event_reg} :
      (reg_addr == MASK_OFS) ? {30'h00000000, irq_mask_reg} :
      (reg_addr == DESC_OFS) ? rx_descriptor : 32'h0000_0000;

   // Link pins pass two flip-flops; the third stage only finds clock edges.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1_reg <= 6'h00;
         sync2_reg <= 6'h00;
         clk_s3_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= {rx_clk_pin, rx_valid_pin, rx_data_pin};
         sync2_reg <= sync1_reg;
         clk_s3_reg <= sync2_reg[5];
      end
   end

   // Register writes; the event set wins over a clear in the same cycle.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rx_control_reg <= CTRL_RESET;
         frame_length_limit <= LIMIT_RESET;
         station_addr_low <= 32'h0000_0000;
         station_addr_high <= 32'h0000_0000;
         unicast_hash_upper <= 32'h0000_0000;
         unicast_hash_lower <= 32'h0000_0000;
         group_hash_upper <= 32'h0000_0000;
         group_hash_lower <= 32'h0000_0000;
         irq_mask_reg <= 2'b00;
         irq_event_reg <= 2'b00;
         reg_rdata <= 32'h0000_0000;
         irq <= 1'b0;
      end
      else
      begin
         if (reg_wr && reg_addr == CTRL_OFS)
            rx_control_reg <= reg_wdata[4:0];
         if (reg_wr && reg_addr == LIMIT_OFS)
            frame_length_limit <= reg_wdata[15:0];
         if (reg_wr && reg_addr == STA_LOW_OFS)
            station_addr_low <= reg_wdata;
         if (reg_wr && reg_addr == STA_HIGH_OFS)
            station_addr_high <= {reg_wdata[31:16], 16'h0000};
         if (reg_wr && reg_addr == UHASH_UP_OFS)
            unicast_hash_upper <= reg_wdata;
         if (reg_wr && reg_addr == UHASH_LO_OFS)
            unicast_hash_lower <= reg_wdata;
         if (reg_wr && reg_addr == GHASH_UP_OFS)
            group_hash_upper <= reg_wdata;
         if (reg_wr && reg_addr == GHASH_LO_OFS)
            group_hash_lower <= reg_wdata;
         if (reg_wr && reg_addr == MASK_OFS)
            irq_mask_reg <= reg_wdata[1:0];
         irq_event_reg <= (irq_event_reg & ~ev_clr) | ev_set;
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
         irq <= |(irq_event_reg & irq_mask_reg);
      end
   end

   // Receive state machine with preamble checks.
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ERXF_IDLE:
            if (sample && mac_enable)
               state_next = ERXF_PRE;
         ERXF_PRE:
            if (frame_end)
               state_next = ERXF_IDLE;
            else if (sample && nibble_mode)
               state_next = nib_sfd ? ERXF_DATA
                          : nib_zero ? ERXF_DROP : ERXF_PRE;
            else if (sample && ser_sfd)
               state_next = ERXF_DATA;
            else if (sample && (ser_bad || ser_alt_err))
               state_next = ERXF_DROP;
         ERXF_DATA:
            if (frame_end)
               state_next = ERXF_IDLE;
            else if (decide_reg && !accept_now)
               state_next = ERXF_DROP;
         ERXF_DROP:
            if (frame_end)
               state_next = ERXF_IDLE;
      endcase
   end

   // Bit counting, nibble pairing and byte assembly.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg <= ERXF_IDLE;
         bit_cnt_reg <= 5'h00;
         prev_bit_reg <= 1'b0;
         prev_nib_reg <= 4'h0;
         shift_reg <= 8'h00;
         part_reg <= 3'h0;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg == ERXF_IDLE)
         begin
            bit_cnt_reg <= 5'h01;
            prev_bit_reg <= serial_rx_bit;
            prev_nib_reg <= data_s;
            part_reg <= 3'h0;
         end
         else if (sample)
         begin
            if (bit_cnt_reg <= SER_ALT_LAST)
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
            prev_bit_reg <= nibble_mode ? data_s[3] : serial_rx_bit;
            prev_nib_reg <= data_s;
            if (state_reg == ERXF_DATA)
            begin
               shift_reg <= nibble_mode ? {4'h0, data_s} : byte_in;
               part_reg <= part_reg + 3'h1;
            end
         end
      end
   end

   // Frame bookkeeping, CRC and address decision.
   always_ff @(posedge clk)
   begin
      if (rst || state_reg == ERXF_IDLE)
      begin
         byte_cnt_reg <= 16'h0000;
         crc_reg <= CRC_INIT;
         da_reg <= 48'h0000_0000_0000;
         type_op_reg <= 32'h0000_0000;
         decide_reg <= 1'b0;
         decided_reg <= 1'b0;
         accepted_reg <= 1'b0;
         miss_reg <= 1'b0;
         bc_reg <= 1'b0;
         mc_reg <= 1'b0;
         pause_cand_reg <= 1'b0;
         pause_reg <= 1'b0;
         over_reg <= 1'b0;
      end
      else
      begin
         decide_reg <= 1'b0;
         if (byte_done)
         begin
            byte_cnt_reg <= byte_cnt_inc;
            crc_reg <= crc_byte(crc_reg, byte_in);
            if (byte_cnt_reg < DA_BYTES)
               da_reg <= {da_reg[39:0], byte_in};
            if (byte_cnt_inc == DA_BYTES)
               decide_reg <= 1'b1;
            if (byte_cnt_reg >= TYPE_FIRST && byte_cnt_inc <= OPCODE_LAST)
               type_op_reg <= {type_op_reg[23:0], byte_in};
            if (byte_cnt_inc > frame_length_limit)
               over_reg <= 1'b1;
         end
         if (decide_reg)
         begin
            decided_reg <= 1'b1;
            miss_reg <= ~addr_hit & accept_all_mode;
            bc_reg <= is_bcast;
            mc_reg <= is_group & ~is_bcast;
            pause_cand_reg <= pause_cand;
         end
         if (decided_reg && byte_cnt_reg == OPCODE_LAST)
            pause_reg <= pause_cand_reg & (type_op_reg == PAUSE_TYPE_OP);
         if (reach_64)
            accepted_reg <= 1'b1;
      end
   end

   // Output strobes, byte stream, status word and descriptor.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rx_byte <= 8'h00;
         rx_byte_valid <= 1'b0;
         frame_accept <= 1'b0;
         frame_reject <= 1'b0;
         status_word <= 32'h0000_0000;
         status_valid <= 1'b0;
         rx_descriptor <= 32'h0000_0000;
      end
      else
      begin
         rx_byte <= byte_in;
         rx_byte_valid <= byte_done & ~(decide_reg & ~accept_now);
         frame_accept <= reach_64 | (end_ok & ~accepted_reg);
         frame_reject <= (decide_reg & ~accept_now & state_reg == ERXF_DATA)
                         | end_flush;
         status_valid <= end_ok;
         if (end_ok)
            status_word <= {8'h00, status_flags};
         if (end_ok)
            rx_descriptor <= {1'b0, 1'b1, 6'h00, status_flags};
         else if (wr_desc && reg_wdata[DESC_EMPTY_BIT])
            rx_descriptor <= {1'b1, 31'h00000000};
      end
   end

   // Checks on the receive and filter behaviour.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_serial_skip_bits: assert property (
      state_reg == ERXF_PRE && !nibble_mode && sample && !frame_end
      && bit_cnt_reg <= SER_IGNORE_BITS |=> state_reg == ERXF_PRE)
      else $error("Serial preamble left during ignored bit times.");
   a_serial_alt_drop: assert property (
      state_reg == ERXF_PRE && !nibble_mode && sample && !ser_sfd
      && ser_alt_err |=> state_reg == ERXF_DROP)
      else $error("Serial alternation error did not drop frame.");
   a_serial_sfd_data: assert property (
      state_reg == ERXF_PRE && !nibble_mode && sample && ser_sfd
      |=> state_reg == ERXF_DATA)
      else $error("Serial delimiter did not start data.");
   a_nibble_sfd_data: assert property (
      state_reg == ERXF_PRE && nibble_mode && sample && nib_sfd
      |=> state_reg == ERXF_DATA)
      else $error("Nibble delimiter did not start data.");
   a_reject_flush: assert property (
      state_reg == ERXF_DATA && decide_reg && !accept_now
      |=> frame_reject && !rx_byte_valid ##1 !rx_byte_valid[*7])
      else $error("Rejected frame was not flushed.");
   a_accept_at_64: assert property (
      $rose(frame_accept) |-> $past(byte_cnt_reg) >= ACCEPT_BYTES - 16'h0001)
      else $error("Frame accepted before 64 bytes.");
   a_bcast_open: assert property (
      decide_reg && is_bcast && !broadcast_block |-> accept_now)
      else $error("Broadcast refused while not blocked.");
   a_bcast_blocked: assert property (
      decide_reg && is_bcast && broadcast_block && !accept_all_mode
      |=> state_reg == ERXF_DROP)
      else $error("Blocked broadcast was not rejected.");
   a_miss_mode: assert property (
      decide_reg |=> miss_reg == ($past(~addr_hit) && accept_all_mode))
      else $error("Miss flag wrong after address decision.");
   a_status_desc: assert property (
      status_valid |-> rx_descriptor[DESC_LAST_BIT]
      && !rx_descriptor[DESC_EMPTY_BIT] ##2 irq_event_reg[EV_FRAME_BIT])
      else $error("Descriptor not completed with status.");
   a_overlength_event: assert property (
      ev_set[EV_OVER_BIT] |=> irq_event_reg[EV_OVER_BIT] && over_reg)
      else $error("Overlength event lost.");

   c_frame_ok: cover property (status_valid);
   c_frame_reject: cover property (frame_reject);
   c_pause_seen: cover property (pause_reg);
   c_nibble_data: cover property (nibble_mode && state_reg == ERXF_DATA);
endmodule : erxf_top
